// *** src/sbna_pkg.sv ***
// sbna_pkg: constants and types for the shared buffer network access block
package sbna_pkg;

   // -------------------------------------------------------------------
   // frame headers
   // -------------------------------------------------------------------
   localparam int HDR_ETH_BYTES = 14;
   localparam int HDR_IP_BYTES = 20;
   localparam int HDR_TCP_BYTES = 20;
   localparam int HDR_UDP_BYTES = 8;
   localparam int HDR_MAX = HDR_ETH_BYTES + HDR_IP_BYTES + HDR_TCP_BYTES;
   localparam logic [5:0] HDR_TCP_LEN = 6'(HDR_ETH_BYTES + HDR_IP_BYTES + HDR_TCP_BYTES);
   localparam logic [5:0] HDR_UDP_LEN = 6'(HDR_ETH_BYTES + HDR_IP_BYTES + HDR_UDP_BYTES);

   // -------------------------------------------------------------------
   // shared buffer and address map
   // -------------------------------------------------------------------
   localparam int BUF_WORDS = 1024;
   localparam int BUF_AW = 10;
   localparam logic [15:0] BUF_SIZE16 = 16'h0400;
   localparam logic [16:0] BUF_LIMIT = 17'h0_0400;
   localparam logic [15:0] PHYS_BASE = 16'h0780;
   localparam logic [15:0] STAT_PHYS = 16'h0200;
   localparam logic [15:0] STAT_RST = 16'h0000;

   // -------------------------------------------------------------------
   // command coding
   // -------------------------------------------------------------------
   localparam int COND_CODE_BIT = 1;
   localparam logic [15:0] MAX_BIN_WORDS = 16'h03F9;
   localparam logic [15:0] MAX_ASC_WORDS = 16'h01FC;
   localparam logic [7:0] CMD_RD = 8'h61;
   localparam logic [7:0] CMD_WR = 8'h60;
   localparam logic [7:0] SUB_ZERO = 8'h00;
   localparam logic [7:0] RSP_FLAG = 8'h80;

   // end codes
   localparam logic [7:0] EC_OK = 8'h00;
   localparam logic [7:0] EC_CMD = 8'h50;
   localparam logic [7:0] EC_RANGE = 8'h51;
   localparam logic [7:0] EC_HEX = 8'h52;
   localparam logic [7:0] EC_SHORT = 8'h53;

   // response buffer
   localparam int FIFO_W = 9;
   localparam int FIFO_DEPTH = 16;

   // -------------------------------------------------------------------
   // state types
   // -------------------------------------------------------------------
   typedef enum logic [3:0] {
      S_HDR, S_SUB, S_ADDR, S_LEN, S_CHECK, S_WDATA, S_DRAIN,
      S_TXHDR, S_TSUB, S_TEC, S_TFETCH, S_TDATA
   } sbna_state_e;

   typedef struct packed {
      sbna_state_e state;
      logic [5:0] hdr_len;
      logic [5:0] hdr_i;
      logic [5:0] e_i;
      logic ascii;
      logic quiet;
      logic bad;
      logic got_last;
      logic is_rd;
      logic [1:0] cnt;
      logic [15:0] acc;
      logic [15:0] sub;
      logic [15:0] ptr;
      logic [15:0] len;
      logic [7:0] endc;
      logic [15:0] stat;
      logic wpend;
      logic [BUF_AW-1:0] waddr;
      logic [15:0] wdata;
      logic rx_rdy;
      logic tx_v;
      logic [7:0] tx_d;
      logic tx_l;
   } sbna_st_s;

endpackage : sbna_pkg

// *** src/sbna_fifo.sv ***
// sbna_fifo: first-in first-out buffer with valid and ready on both sides
`timescale 1ns/1ps
module sbna_fifo #(
   parameter int W = 9,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [AW:0] wp;
      logic [AW:0] rp;
   } sbna_fptr_s;

   sbna_fptr_s st_r;
   sbna_fptr_s st_nxt;
   logic [W-1:0] mem [DEPTH];
   logic [AW:0] used;

   // -------------------------------------------------------------------
   // flags
   // -------------------------------------------------------------------
   assign used = st_r.wp - st_r.rp;
   assign in_ready = (used != (AW+1)'(DEPTH));
   assign out_valid = (used != '0);
   assign out_data = mem[st_r.rp[AW-1:0]];

   // pointer advance
   always_comb begin
      st_nxt = st_r;
      if (in_valid && in_ready) begin
         st_nxt.wp = st_r.wp + 1'b1;
      end
      if (out_valid && out_ready) begin
         st_nxt.rp = st_r.rp + 1'b1;
      end
   end

   // storage
   always_ff @(posedge clk) begin
      if (in_valid && in_ready) begin
         mem[st_r.wp[AW-1:0]] <= in_data;
      end
   end

   // state register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

endmodule : sbna_fifo

// *** src/sbna_top.sv ***
// sbna_top: network command interpreter for the shared word buffer
//
// Behaviour
// - frames use 14-byte link, 20-byte network, 20-byte TCP or 8-byte UDP headers
// - headers are stripped on receive and added on transmit by the block
// - data fields are binary or ASCII hex, fixed by configuration for both ends
// - bit 1 of the condition word: 0 binary, 1 ASCII
// - in ASCII the start address is hex characters, decoded here
// - length counts 16-bit words in the buffer, at most 1017 in binary
// - in ASCII the length is hex characters, at most 508 words
// - the length covers the text: words written or words returned
// - every response carries an end code
// - each end code is kept in a status word the controller reads
// - binary read starts 61h 00h, address and length low byte first
// - ASCII read starts characters 36h 31h 30h 30h, then hex fields
// - commands are served only after initial and open processes complete
// - only on fixed-buffer handshake connections while open is complete
// - the controller cannot trigger sends nor see receive completion
// - logical addresses map onto different physical buffer addresses
`timescale 1ns/1ps
module sbna_top
   import sbna_pkg::*;
(
   input wire logic SYS_CLK,
   input wire logic NRST,
   input wire logic RX_VALID,
   output logic RX_READY,
   input wire logic [7:0] RX_DATA,
   input wire logic RX_LAST,
   input wire logic RX_UDP,
   output logic TX_VALID,
   input wire logic TX_READY,
   output logic [7:0] TX_DATA,
   output logic TX_LAST,
   input wire logic [15:0] COND_WORD,
   input wire logic INIT_DONE,
   input wire logic OPEN_DONE,
   input wire logic FIXED_PROC,
   input wire logic [15:0] LOC_ADDR,
   input wire logic LOC_WR,
   input wire logic [15:0] LOC_WDATA,
   output logic [15:0] LOC_RDATA
);

   sbna_st_s st_r;
   sbna_st_s st_nxt;
   logic [15:0] mem [BUF_WORDS];
   logic [7:0] hdr_mem [HDR_MAX];
   logic [15:0] mem_q;
   logic [15:0] loc_q;
   logic take;
   logic gate_open;
   logic code_sel;
   logic [4:0] rx_hex;
   logic [15:0] lim;
   logic [16:0] span;
   logic push;
   logic [7:0] push_d;
   logic push_l;
   logic fifo_in_rdy;
   logic fifo_out_v;
   logic fifo_out_rdy;
   logic [8:0] fifo_out_d;
   logic [15:0] loc_off;
   logic loc_buf_hit;
   logic loc_wr_hit;

   // -------------------------------------------------------------------
   // helper functions
   // -------------------------------------------------------------------
   // ascii hex character to {bad, nibble}
   function automatic logic [4:0] hex_in(input logic [7:0] c);
      if (c >= 8'h30 && c <= 8'h39) begin
         hex_in = {1'b0, 4'(c - 8'h30)};
      end else if (c >= 8'h41 && c <= 8'h46) begin
         hex_in = {1'b0, 4'(c - 8'h37)};
      end else begin
         hex_in = 5'h10;
      end
   endfunction : hex_in

   // last byte or character of a 16-bit field
   function automatic logic unit_last(input logic [1:0] k, input logic asc);
      unit_last = (k == (asc ? 2'd3 : 2'd1));
   endfunction : unit_last

   // last byte of an outgoing field of one or two bytes
   function automatic logic emit_last(input logic [2:0] k, input logic two, input logic asc);
      logic [2:0] n;
      n = asc ? (two ? 3'd3 : 3'd1) : (two ? 3'd1 : 3'd0);
      emit_last = (k == n);
   endfunction : emit_last

   // byte k of a field: binary low byte first, ascii high nibble first
   function automatic logic [7:0] emit_byte(input logic [15:0] v, input logic [2:0] k,
                                            input logic two, input logic asc);
      logic [1:0] n;
      logic [3:0] nib;
      n = two ? 2'(3'd3 - k) : 2'(3'd1 - k);
      nib = 4'(v >> {n, 2'b00});
      if (asc) begin
         emit_byte = (nib < 4'hA) ? (8'h30 + {4'h0, nib}) : (8'h37 + {4'h0, nib});
      end else begin
         emit_byte = k[0] ? v[15:8] : v[7:0];
      end
   endfunction : emit_byte

   // -------------------------------------------------------------------
   // shared decode
   // -------------------------------------------------------------------
   assign take = RX_VALID && st_r.rx_rdy;
   assign gate_open = INIT_DONE && OPEN_DONE && FIXED_PROC;
   assign code_sel = COND_WORD[COND_CODE_BIT];
   assign rx_hex = hex_in(RX_DATA);
   assign lim = st_r.ascii ? MAX_ASC_WORDS : MAX_BIN_WORDS;
   assign span = {1'b0, st_r.ptr} + {1'b0, st_r.len};
   assign loc_off = LOC_ADDR - PHYS_BASE;
   assign loc_buf_hit = (LOC_ADDR >= PHYS_BASE) && (loc_off < BUF_SIZE16);
   assign loc_wr_hit = LOC_WR && loc_buf_hit;
   assign fifo_out_rdy = !st_r.tx_v || TX_READY;

   // -------------------------------------------------------------------
   // command interpreter next state
   // -------------------------------------------------------------------
   always_comb begin
      logic [15:0] acc_n;
      logic ulast;
      logic is_rd;
      logic is_wr;
      logic [7:0] chk;
      logic [7:0] rsp;
      logic [15:0] ev;
      logic two;
      logic elast;
      st_nxt = st_r;
      push = 1'b0;
      push_d = 8'h00;
      push_l = 1'b0;
      acc_n = st_r.ascii ? {st_r.acc[11:0], rx_hex[3:0]} : {RX_DATA, st_r.acc[15:8]};
      ulast = unit_last(st_r.cnt, st_r.ascii);
      is_rd = st_r.sub == (st_r.ascii ? {CMD_RD, SUB_ZERO} : {SUB_ZERO, CMD_RD});
      is_wr = st_r.sub == (st_r.ascii ? {CMD_WR, SUB_ZERO} : {SUB_ZERO, CMD_WR});
      rsp = (st_r.ascii ? st_r.sub[15:8] : st_r.sub[7:0]) | RSP_FLAG;
      two = (st_r.state != S_TEC);
      if (st_r.state == S_TSUB) begin
         ev = st_r.ascii ? {rsp, 8'h00} : {8'h00, rsp};
      end else if (st_r.state == S_TEC) begin
         ev = {8'h00, st_r.endc};
      end else begin
         ev = mem_q;
      end
      elast = emit_last(st_r.e_i[2:0], two, st_r.ascii);
      if (st_r.bad) begin
         chk = EC_HEX;
      end else if (st_r.len > lim || span > BUF_LIMIT) begin
         chk = EC_RANGE;
      end else if (!is_rd && !is_wr) begin
         chk = EC_CMD;
      end else begin
         chk = EC_OK;
      end
      // pending remote word leaves once the local side is not writing
      if (st_r.wpend && !loc_wr_hit) begin
         st_nxt.wpend = 1'b0;
      end
      // field accumulation
      if (take && (st_r.state inside {S_SUB, S_ADDR, S_LEN, S_WDATA})) begin
         st_nxt.acc = acc_n;
         st_nxt.cnt = st_r.cnt + 2'd1;
         if (st_r.ascii && rx_hex[4]) begin
            st_nxt.bad = 1'b1;
         end
      end
      case (st_r.state)
         S_HDR: if (take) begin
            if (st_r.hdr_i == 6'h00) begin
               st_nxt.hdr_len = RX_UDP ? HDR_UDP_LEN : HDR_TCP_LEN;
               st_nxt.ascii = code_sel;
               st_nxt.quiet = !gate_open;
               st_nxt.bad = 1'b0;
               st_nxt.got_last = 1'b0;
               st_nxt.cnt = 2'd0;
               st_nxt.endc = EC_OK;
            end
            if (RX_LAST) begin
               st_nxt.hdr_i = 6'h00;
            end else if (st_r.hdr_i == st_nxt.hdr_len - 6'h01) begin
               st_nxt.hdr_i = 6'h00;
               st_nxt.state = st_nxt.quiet ? S_DRAIN : S_SUB;
            end else begin
               st_nxt.hdr_i = st_r.hdr_i + 6'h01;
            end
         end
         S_SUB, S_ADDR, S_LEN: if (take) begin
            if (ulast) begin
               st_nxt.cnt = 2'd0;
               if (st_r.state == S_SUB) begin
                  st_nxt.sub = acc_n;
                  st_nxt.state = S_ADDR;
               end else if (st_r.state == S_ADDR) begin
                  st_nxt.ptr = acc_n;
                  st_nxt.state = S_LEN;
               end else begin
                  st_nxt.len = acc_n;
                  st_nxt.state = S_CHECK;
               end
            end
            if (RX_LAST) begin
               st_nxt.got_last = 1'b1;
               if (!(ulast && st_r.state == S_LEN)) begin
                  st_nxt.endc = EC_SHORT;
                  st_nxt.state = S_TXHDR;
               end
            end
         end
         S_CHECK: begin
            st_nxt.is_rd = is_rd;
            st_nxt.endc = chk;
            if (chk == EC_OK && is_wr && st_r.len != 16'h0000) begin
               st_nxt.endc = st_r.got_last ? EC_SHORT : EC_OK;
               st_nxt.state = st_r.got_last ? S_TXHDR : S_WDATA;
            end else begin
               st_nxt.state = st_r.got_last ? S_TXHDR : S_DRAIN;
            end
         end
         S_WDATA: if (take) begin
            if (ulast) begin
               st_nxt.cnt = 2'd0;
               st_nxt.wpend = 1'b1;
               st_nxt.waddr = st_r.ptr[BUF_AW-1:0];
               st_nxt.wdata = acc_n;
               st_nxt.ptr = st_r.ptr + 16'h0001;
               st_nxt.len = st_r.len - 16'h0001;
               if (st_r.len == 16'h0001) begin
                  st_nxt.state = S_DRAIN;
               end
            end
            if (RX_LAST) begin
               st_nxt.got_last = 1'b1;
               st_nxt.state = S_TXHDR;
               if (!(ulast && st_r.len == 16'h0001)) begin
                  st_nxt.endc = EC_SHORT;
               end
            end
         end
         S_DRAIN: if (st_r.got_last || (take && RX_LAST)) begin
            st_nxt.state = st_r.quiet ? S_HDR : S_TXHDR;
         end
         S_TXHDR: if (fifo_in_rdy) begin
            push = 1'b1;
            push_d = hdr_mem[st_r.e_i];
            if (st_r.e_i == st_r.hdr_len - 6'h01) begin
               st_nxt.e_i = 6'h00;
               st_nxt.state = S_TSUB;
            end else begin
               st_nxt.e_i = st_r.e_i + 6'h01;
            end
         end
         S_TSUB, S_TEC: if (fifo_in_rdy) begin
            push = 1'b1;
            push_d = emit_byte(ev, st_r.e_i[2:0], two, st_r.ascii);
            push_l = (st_r.state == S_TEC) && elast &&
                     !(st_r.is_rd && st_r.endc == EC_OK && st_r.len != 16'h0000);
            st_nxt.e_i = elast ? 6'h00 : st_r.e_i + 6'h01;
            if (elast) begin
               st_nxt.state = (st_r.state == S_TSUB) ? S_TEC : (push_l ? S_HDR : S_TFETCH);
            end
         end
         S_TFETCH: st_nxt.state = S_TDATA;
         S_TDATA: if (fifo_in_rdy) begin
            push = 1'b1;
            push_d = emit_byte(ev, st_r.e_i[2:0], 1'b1, st_r.ascii);
            push_l = elast && st_r.len == 16'h0001;
            st_nxt.e_i = elast ? 6'h00 : st_r.e_i + 6'h01;
            if (elast) begin
               st_nxt.ptr = st_r.ptr + 16'h0001;
               st_nxt.len = st_r.len - 16'h0001;
               st_nxt.state = push_l ? S_HDR : S_TFETCH;
            end
         end
         default: st_nxt.state = S_HDR;
      endcase
      // a finished frame must not keep the receiver closed for the next one
      if (st_nxt.state == S_HDR) begin
         st_nxt.got_last = 1'b0;
      end
      if (st_nxt.state == S_TXHDR && st_r.state != S_TXHDR) begin
         st_nxt.stat = {8'h00, st_nxt.endc};
      end
      st_nxt.rx_rdy = (st_nxt.state inside {S_HDR, S_SUB, S_ADDR, S_LEN, S_WDATA, S_DRAIN})
                      && !st_nxt.wpend && !st_nxt.got_last;
      // output register stage after the fifo
      if (fifo_out_rdy) begin
         st_nxt.tx_v = fifo_out_v;
         st_nxt.tx_d = fifo_out_d[7:0];
         st_nxt.tx_l = fifo_out_d[8];
      end
   end

   // state register
   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // -------------------------------------------------------------------
   // buffer memory, local side has write priority
   // -------------------------------------------------------------------
   // shared storage
   always_ff @(posedge SYS_CLK) begin
      if (loc_wr_hit) begin
         mem[loc_off[BUF_AW-1:0]] <= LOC_WDATA;
      end else if (st_r.wpend) begin
         mem[st_r.waddr] <= st_r.wdata;
      end
      if (take && st_r.state == S_HDR) begin
         hdr_mem[st_r.hdr_i] <= RX_DATA;
      end
   end

   // read ports; no send trigger or receive-done flag on the local side
   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         mem_q <= 16'h0000;
         loc_q <= STAT_RST;
      end else begin
         mem_q <= mem[st_r.ptr[BUF_AW-1:0]];
         if (LOC_ADDR == STAT_PHYS) begin
            loc_q <= st_r.stat;
         end else if (loc_buf_hit) begin
            loc_q <= mem[loc_off[BUF_AW-1:0]];
         end else begin
            loc_q <= 16'h0000;
         end
      end
   end

   // response buffer with back-pressure into the emitter
   sbna_fifo #(.W(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(SYS_CLK),
      .rst_n(NRST),
      .in_valid(push),
      .in_ready(fifo_in_rdy),
      .in_data({push_l, push_d}),
      .out_valid(fifo_out_v),
      .out_ready(fifo_out_rdy),
      .out_data(fifo_out_d)
   );

   assign RX_READY = st_r.rx_rdy;
   assign TX_VALID = st_r.tx_v;
   assign TX_DATA = st_r.tx_d;
   assign TX_LAST = st_r.tx_l;
   assign LOC_RDATA = loc_q;

   // -------------------------------------------------------------------
   // assertions
   // -------------------------------------------------------------------
   sequence s_frame_start;
      take && st_r.state == S_HDR && st_r.hdr_i == 6'h00;
   endsequence

   sequence s_check_ok;
      st_r.state == S_CHECK && !st_r.bad && st_r.len <= lim && span <= BUF_LIMIT;
   endsequence

   a_hdr_len: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      s_frame_start |=> st_r.hdr_len == ($past(RX_UDP) ? HDR_UDP_LEN : HDR_TCP_LEN))
      else $error("header length not taken from protocol");

   a_code_select: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      s_frame_start |=> st_r.ascii == $past(code_sel))
      else $error("coding not taken from condition word");

   a_gate_quiet: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      (s_frame_start ##0 !gate_open) |=> st_r.quiet ##0 !push [*8])
      else $error("closed connection produced a response");

   a_hex_bad: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      take && st_r.ascii && rx_hex[4] && (st_r.state inside {S_SUB, S_ADDR, S_LEN})
      |=> st_r.bad)
      else $error("bad hex character not flagged");

   a_len_limit: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      st_r.state == S_CHECK && !st_r.bad && st_r.len > lim
      |=> st_r.endc == EC_RANGE && st_r.state != S_WDATA && !st_r.wpend)
      else $error("over-limit count not rejected");

   a_bin_read: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      (s_check_ok ##0 !st_r.ascii && st_r.sub == {SUB_ZERO, CMD_RD})
      |=> st_r.is_rd && st_r.endc == EC_OK)
      else $error("binary read not recognised");

   a_asc_read: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      (s_check_ok ##0 st_r.ascii && st_r.sub == {CMD_RD, SUB_ZERO})
      |=> st_r.is_rd && st_r.endc == EC_OK)
      else $error("ascii read not recognised");

   a_end_code: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      push && st_r.state == S_TEC && !st_r.ascii |-> push_d == st_r.endc)
      else $error("end code byte wrong");

   a_stat_rec: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      (st_r.state != S_TXHDR ##1 st_r.state == S_TXHDR) |-> st_r.stat[7:0] == st_r.endc)
      else $error("end code not recorded");

   a_phys_map: assert property (@(posedge SYS_CLK) disable iff (!NRST)
      (st_r.wpend && !loc_wr_hit ##1
       LOC_ADDR == 16'(PHYS_BASE + {6'h00, $past(st_r.waddr)}) && !LOC_WR)
      |=> LOC_RDATA == $past(st_r.wdata, 2))
      else $error("remote word not seen at physical address");

endmodule : sbna_top

// *** tb/sbna_remote.sv ***
// sbna_remote: remote station that sends buffer commands and collects responses
`timescale 1ns/1ps
module sbna_remote (
   input wire logic clk,
   output logic rx_valid,
   input wire logic rx_ready,
   output logic [7:0] rx_data,
   output logic rx_last,
   input wire logic tx_valid,
   output logic tx_ready,
   input wire logic [7:0] tx_data,
   input wire logic tx_last
);
   logic [7:0] rsp[$];
   int frames = 0;
   initial begin
      rx_valid = 1'b0;
      rx_data = 8'h00;
      rx_last = 1'b0;
      tx_ready = 1'b0;
   end
   // sink stalls every other cycle so the emitter must hold its byte
   always @(posedge clk) begin
      if (tx_valid && tx_ready) begin
         rsp.push_back(tx_data);
         if (tx_last) frames++;
      end
      tx_ready <= #1 ~tx_ready;
   end
   // one byte per accepted cycle, held until ready is seen; data is inverted once on going idle
   task automatic send(input logic [7:0] b[$]);
      for (int i = 0; i < b.size(); i++) begin
         rx_valid = 1'b1;
         rx_data = b[i];
         rx_last = (i == b.size() - 1);
         do @(posedge clk); while (!rx_ready);
         #1;
      end
      rx_valid = 1'b0;
      rx_data = ~rx_data;
      rx_last = 1'b0;
   endtask : send
endmodule : sbna_remote

// *** tb/sbna_top_bench.sv ***
// sbna_top_bench: self-checking bench for the network buffer interpreter
`timescale 1ns/1ps
module sbna_top_bench;
   import sbna_pkg::*;
   logic clk = 0, nrst = 0, rx_valid, rx_ready, rx_last, rx_udp = 0;
   logic tx_valid, tx_ready, tx_last, init_done = 1, open_done = 1, fixed_proc = 1;
   logic [7:0] rx_data, tx_data;
   logic [15:0] cond_word = 16'h0000, loc_addr = 16'h0000, loc_wdata = 16'h0000, loc_rdata;
   logic loc_wr = 0;
   logic [7:0] f[$];
   int fails = 0, total_checks = 0;

   sbna_top u_dut (.SYS_CLK(clk), .NRST(nrst), .RX_VALID(rx_valid), .RX_READY(rx_ready),
      .RX_DATA(rx_data), .RX_LAST(rx_last), .RX_UDP(rx_udp), .TX_VALID(tx_valid),
      .TX_READY(tx_ready), .TX_DATA(tx_data), .TX_LAST(tx_last), .COND_WORD(cond_word),
      .INIT_DONE(init_done), .OPEN_DONE(open_done), .FIXED_PROC(fixed_proc),
      .LOC_ADDR(loc_addr), .LOC_WR(loc_wr), .LOC_WDATA(loc_wdata), .LOC_RDATA(loc_rdata));
   sbna_remote rp (.clk(clk), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
      .rx_last(rx_last), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
      .tx_last(tx_last));

   initial begin
      forever #50 clk = ~clk;
   end

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : report_and_stop

   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      total_checks++;
      if (g !== e) begin
         fails++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk

   // fresh frame with a recognisable header of the chosen kind
   task automatic hdr(input bit udp);
      f.delete();
      for (int i = 0; i < (udp ? 42 : 54); i++) f.push_back(8'(i) + 8'h20);
      rx_udp = udp;
   endtask : hdr

   // send frame, wait for the answer, compare header copy and tail
   task automatic xfer(input logic [7:0] e[$]);
      int n;
      int h;
      n = rp.frames;
      h = rx_udp ? 42 : 54;
      rp.rsp.delete();
      rp.send(f);
      for (int i = 0; i < 600 && rp.frames == n; i++) @(posedge clk);
      #1;
      chk(16'(rp.frames - n), 16'h0001);
      chk(16'(rp.rsp.size()), 16'(h + e.size()));
      if (rp.rsp.size() == h + e.size()) begin
         for (int i = 0; i < h; i++) chk(16'(rp.rsp[i]), 16'(f[i]));
         for (int i = 0; i < e.size(); i++) chk(16'(rp.rsp[h + i]), 16'(e[i]));
      end
   endtask : xfer

   task automatic lrd(input logic [15:0] a, input logic [15:0] e);
      loc_addr = a;
      @(posedge clk);
      #1;
      chk(loc_rdata, e);
   endtask : lrd

   task automatic lwr(input logic [15:0] a, input logic [15:0] d);
      loc_addr = a;
      loc_wdata = d;
      loc_wr = 1'b1;
      @(posedge clk);
      #1;
      loc_wr = 1'b0;
   endtask : lwr

   task automatic s_gate;
      open_done = 1'b0;
      hdr(0);
      f = {f, 8'h61, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00};
      rp.send(f);
      repeat (200) @(posedge clk);
      #1;
      chk(16'(rp.frames), 16'h0000);
      open_done = 1'b1;
   endtask : s_gate

   task automatic s_range;
      lwr(16'h0B7F, 16'h1111);
      hdr(0);
      f = {f, 8'h60, 8'h00, 8'hFF, 8'h03, 8'h02, 8'h00, 8'hAA, 8'hAA, 8'hBB, 8'hBB};
      xfer({8'hE0, 8'h00, 8'h51});
      lrd(16'h0B7F, 16'h1111);
      lrd(16'h0200, 16'h0051);
      hdr(0);
      f = {f, 8'h61, 8'h00, 8'h00, 8'h00, 8'hFA, 8'h03};
      xfer({8'hE1, 8'h00, 8'h51});
      hdr(0);
      f = {f, 8'h61, 8'h00, 8'h14};
      xfer({8'hE1, 8'h00, 8'h53});
      lrd(16'h0200, 16'h0053);
      hdr(0);
      f = {f, 8'h62, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00};
      xfer({8'hE2, 8'h00, 8'h50});
   endtask : s_range

   task automatic s_bin;
      hdr(0);
      f = {f, 8'h60, 8'h00, 8'h14, 8'h00, 8'h02, 8'h00, 8'h34, 8'h12, 8'h78, 8'h56};
      // local side watches the flag word while the remote writes it
      loc_addr = 16'h0795;
      xfer({8'hE0, 8'h00, 8'h00});
      lrd(16'h0794, 16'h1234);
      lrd(16'h0795, 16'h5678);
      lrd(16'h0200, 16'h0000);
      hdr(0);
      f = {f, 8'h61, 8'h00, 8'h15, 8'h00, 8'h01, 8'h00};
      xfer({8'hE1, 8'h00, 8'h00, 8'h78, 8'h56});
   endtask : s_bin

   task automatic s_ascii;
      cond_word = 16'h0002;
      hdr(1);
      f = {f, 8'h36, 8'h31, 8'h30, 8'h30, 8'h30, 8'h30, 8'h31, 8'h34};
      f = {f, 8'h30, 8'h30, 8'h30, 8'h31};
      xfer({8'h45, 8'h31, 8'h30, 8'h30, 8'h30, 8'h30, 8'h31, 8'h32, 8'h33, 8'h34});
      hdr(1);
      f = {f, 8'h36, 8'h31, 8'h30, 8'h30, 8'h30, 8'h30, 8'h30, 8'h30};
      f = {f, 8'h30, 8'h31, 8'h46, 8'h44};
      xfer({8'h45, 8'h31, 8'h30, 8'h30, 8'h35, 8'h31});
      hdr(1);
      f = {f, 8'h36, 8'h31, 8'h30, 8'h30, 8'h30, 8'h30, 8'h47, 8'h30};
      f = {f, 8'h30, 8'h30, 8'h30, 8'h31};
      xfer({8'h45, 8'h31, 8'h30, 8'h30, 8'h35, 8'h32});
      cond_word = 16'h0000;
   endtask : s_ascii

   initial begin
      repeat (12) @(posedge clk);
      #1;
      nrst = 1'b1;
      repeat (2) @(posedge clk);
      #1;
      s_gate();
      s_range();
      s_bin();
      s_ascii();
      report_and_stop();
   end

   // watchdog sized well above the expected few thousand cycles
   initial begin
      #(20000 * 100);
      fails++;
      report_and_stop();
   end
endmodule : sbna_top_bench
